// >>> rtl/dae_pkg.sv
/*
 Types for the acknowledge/error-report and video sequencing block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dae_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SHIFT = 2'h1,
		ST_TURN  = 2'h3
	} dae_st_t;
	typedef enum logic [1:0] {
		VM_PULSE = 2'h0,
		VM_EVENT = 2'h1,
		VM_BURST = 2'h2
	} dae_vmode_t;
	typedef enum logic [2:0] {
		PK_VSS   = 3'h0,
		PK_VSE   = 3'h1,
		PK_HSS   = 3'h2,
		PK_HSE   = 3'h3,
		PK_BLANK = 3'h4,
		PK_PIXEL = 3'h5,
		PK_OTHER = 3'h6
	} dae_pkt_t;
	typedef struct packed {
		logic     valid;
		dae_pkt_t kind;
	} dae_vid_t;
	typedef struct packed {
		logic valid;
		logic bta;
		logic rd;
		logic rd2;
	} dae_hend_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} dae_wbreq_t;
	typedef struct packed {
		dae_st_t     st;
		logic [15:0] err;
		logic [15:0] rep;
		logic [63:0] sbuf;
		logic [6:0]  bits;
		logic        tbit;
		logic [1:0]  mode;
		logic [1:0]  vc;
		logic [7:0]  syncw;
		logic        ack;
		logic [31:0] dat;
		logic        s1;
		logic        s2;
		logic        s3;
		logic        lvl;
		logic        vs;
		logic        hs;
		logic [7:0]  vcnt;
		logic [7:0]  hcnt;
		logic        line_open;
		logic        line_rdy;
		logic        exec;
		logic [15:0] line_cnt;
		logic [15:0] frame_cnt;
	} dae_state_t;
endpackage

// >>> rtl/dae_regs.svh
/*
 Register offsets, field values and lane constants for the
 acknowledge/error-report and video sequencing block.
 Assumes inclusion by bare name from the block's design file.
*/
`ifndef DAE_REGS_SVH
`define DAE_REGS_SVH
`define DAE_CTRL_ADR  8'h00
`define DAE_ERR_ADR   8'h04
`define DAE_SYNC_ADR  8'h08
`define DAE_CNT_ADR   8'h0C
`define DAE_SYNCW_RST 8'h10
// 00100001 first-to-last, sent LSB first
`define DAE_ACK_TRIG  8'h84
`define DAE_DT_ACKERR 6'h02
`define DAE_DT_RD1    6'h21
`define DAE_DT_RD2    6'h22
`define DAE_ERR_KEEP  16'hBFFF
`define DAE_ERR_SB    16'h0100
`define DAE_ERR_NOEX  16'h9A03
`define DAE_ERR_PROTO 16'h8000
`define DAE_ECC_P0    24'hF12CB7
`define DAE_ECC_P1    24'hF2555B
`define DAE_ECC_P2    24'h749A6D
`define DAE_ECC_P3    24'hB8E38E
`define DAE_ECC_P4    24'hDF03F0
`define DAE_ECC_P5    24'hEFFC00
`endif

// >>> rtl/dae_top.sv
/*
 Peripheral-side response framer and video sequence tracker.
 Assumes an upstream packet decoder on clk_i that reports host packets,
 per-transmission error flags and the end of each host transmission.
*/
// The placing of the registers and the Wishbone register port were left to the implementer.
// Functional notes
// - plain acknowledge is trigger byte 00100001
// - read response: identifier, two data, ECC
// - one-byte read: second data byte zero
// - error report: identifier, errors low, high, ECC
// - each detected error sets its bit
// - bits 0-7 carry physical layer errors
// - bit 8 single ECC, bit 9 multi ECC
// - bits 10-13,15 protocol errors; 14 reserved
// - errors accumulate until reported
// - blanking may idle or carry other packets
// - device talks only after host turnaround
// - accept any packet order while well formed
// - pulse mode rebuilds sync pulse widths
// - event mode: single sync event packets
// - burst pixels held, shown at panel rate; no store here, only a line_rdy_o pulse per line
// - reported errors cleared after report
// - turnaround after every device transmission
// - no turnaround request means no answer
// - multi-bit error command discarded, report only
`timescale 1ns/1ps
`include "dae_regs.svh"
module dae_top (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire dae_pkg::dae_wbreq_t wb_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	// Host packet decoder
	input  wire dae_pkg::dae_vid_t  vid_i,
	input  wire dae_pkg::dae_hend_t hend_i,
	input  wire logic [15:0]        err_i,
	input  wire logic [15:0]        rd_data_i,
	// Link clock lane and reverse lane
	input  wire logic               lclk_i,
	output logic                    tx_bit_o,
	output logic                    tx_oe_o,
	output logic                    turn_o,
	// Display side
	output logic                    exec_o,
	output logic                    vsync_o,
	output logic                    hsync_o,
	output logic                    line_rdy_o
);
	dae_pkg::dae_state_t r;
	dae_pkg::dae_state_t n;
	logic        rise;
	logic        proto;
	logic [15:0] errs;
	logic        rd_ok;
	logic [31:0] rep_pkt;
	logic [31:0] rsp_pkt;
	logic [7:0]  di_rep;
	logic [7:0]  di_rsp;
	logic [7:0]  rd_hi;

	function automatic logic [7:0] ecc_f(input logic [23:0] d);
		ecc_f = {2'b00, ^(d & `DAE_ECC_P5), ^(d & `DAE_ECC_P4),
			^(d & `DAE_ECC_P3), ^(d & `DAE_ECC_P2),
			^(d & `DAE_ECC_P1), ^(d & `DAE_ECC_P0)};
	endfunction

	// Pixel with no line start since the last pixel is a protocol fault
	assign proto = vid_i.valid && vid_i.kind == dae_pkg::PK_PIXEL && !r.line_open;
	assign errs = r.err | ((err_i | (proto ? `DAE_ERR_PROTO : 16'h0000)) & `DAE_ERR_KEEP);
	assign rd_ok = hend_i.rd && ((errs & ~`DAE_ERR_SB) == 16'h0000);
	assign di_rep = {r.vc, `DAE_DT_ACKERR};
	assign di_rsp = {r.vc, hend_i.rd2 ? `DAE_DT_RD2 : `DAE_DT_RD1};
	assign rd_hi = hend_i.rd2 ? rd_data_i[15:8] : 8'h00;
	assign rep_pkt = {ecc_f({errs, di_rep}), errs[15:8], errs[7:0], di_rep};
	assign rsp_pkt = {ecc_f({rd_hi, rd_data_i[7:0], di_rsp}), rd_hi, rd_data_i[7:0], di_rsp};

	always_comb begin
		n = r;
		rise = 1'b0;
		n.s1 = lclk_i;
		n.s2 = r.s1;
		n.s3 = r.s2;
		if (r.s2 == r.s3 && r.s3 != r.lvl) begin
			n.lvl = r.s3;
			rise = r.s3;
		end
		// Register bus, one wait state
		n.ack = wb_i.cyc & wb_i.stb & ~r.ack;
		if (n.ack && !wb_i.we) begin
			case (wb_i.adr)
				`DAE_CTRL_ADR: n.dat = {16'h0000, r.syncw, 4'h0, r.vc, r.mode};
				`DAE_ERR_ADR:  n.dat = {16'h0000, r.err};
				`DAE_SYNC_ADR: n.dat = {26'h0000000, r.st, 1'b0, r.line_open, r.hs, r.vs};
				`DAE_CNT_ADR:  n.dat = {r.frame_cnt, r.line_cnt};
				default:       n.dat = 32'h00000000;
			endcase
		end
		if (n.ack && wb_i.we && wb_i.adr == `DAE_CTRL_ADR) begin
			if (wb_i.sel[0]) begin
				n.mode = wb_i.dat[1:0];
				n.vc = wb_i.dat[3:2];
			end
			if (wb_i.sel[1])
				n.syncw = wb_i.dat[15:8];
		end
		// Errors gathered every cycle, new flags win over clearing
		n.err = errs;
		n.exec = hend_i.valid && !hend_i.rd && ((err_i & `DAE_ERR_NOEX) == 16'h0000);
		// Video timing rebuild
		n.line_rdy = 1'b0;
		if (r.mode != dae_pkg::VM_PULSE) begin
			if (r.vcnt != 8'h00)
				n.vcnt = r.vcnt - 8'h01;
			if (r.hcnt != 8'h00)
				n.hcnt = r.hcnt - 8'h01;
			if (r.vcnt == 8'h01)
				n.vs = 1'b0;
			if (r.hcnt == 8'h01)
				n.hs = 1'b0;
		end
		if (vid_i.valid) begin
			case (vid_i.kind)
				dae_pkg::PK_VSS: begin
					n.vs = 1'b1;
					n.vcnt = r.syncw;
					n.line_open = 1'b1;
					n.line_cnt = 16'h0000;
					n.frame_cnt = r.frame_cnt + 16'h0001;
				end
				dae_pkg::PK_VSE: begin
					if (r.mode == dae_pkg::VM_PULSE)
						n.vs = 1'b0;
					n.line_open = 1'b1;
					n.line_cnt = r.line_cnt + 16'h0001;
				end
				dae_pkg::PK_HSS: begin
					n.hs = 1'b1;
					n.hcnt = r.syncw;
					n.line_open = 1'b1;
					n.line_cnt = r.line_cnt + 16'h0001;
				end
				dae_pkg::PK_HSE: begin
					if (r.mode == dae_pkg::VM_PULSE)
						n.hs = 1'b0;
				end
				dae_pkg::PK_PIXEL: begin
					// Line store lives downstream; burst lines drain at panel rate
					n.line_rdy = r.line_open;
					n.line_open = 1'b0;
				end
				default: begin
					// Blanking and other traffic leave line state alone
				end
			endcase
		end
		// Reverse transmission only in answer to a turnaround
		case (r.st)
			dae_pkg::ST_IDLE: begin
				if (hend_i.valid && hend_i.bta) begin
					n.st = dae_pkg::ST_SHIFT;
					n.rep = errs;
					if (errs == 16'h0000 && !hend_i.rd) begin
						n.sbuf = {56'h0, `DAE_ACK_TRIG};
						n.bits = 7'h08;
					end else if (errs == 16'h0000) begin
						n.sbuf = {32'h0, rsp_pkt};
						n.bits = 7'h20;
					end else if (rd_ok) begin
						n.sbuf = {rep_pkt, rsp_pkt};
						n.bits = 7'h40;
					end else begin
						n.sbuf = {32'h0, rep_pkt};
						n.bits = 7'h20;
					end
				end
			end
			dae_pkg::ST_SHIFT: begin
				if (rise) begin
					if (r.bits == 7'h00) begin
						n.st = dae_pkg::ST_TURN;
					end else begin
						n.tbit = r.sbuf[0];
						n.sbuf = {1'b0, r.sbuf[63:1]};
						n.bits = r.bits - 7'h01;
					end
				end
			end
			dae_pkg::ST_TURN: begin
				n.err = errs & ~(r.rep & ~((err_i | (proto ? `DAE_ERR_PROTO : 16'h0000)) & `DAE_ERR_KEEP));
				n.rep = 16'h0000;
				n.tbit = 1'b0;
				n.st = dae_pkg::ST_IDLE;
			end
			default: n.st = dae_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.syncw <= `DAE_SYNCW_RST;
		end else begin
			r <= n;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign tx_bit_o = r.tbit;
	assign tx_oe_o = r.st == dae_pkg::ST_SHIFT;
	assign turn_o = r.st == dae_pkg::ST_TURN;
	assign exec_o = r.exec;
	assign vsync_o = r.vs;
	assign hsync_o = r.hs;
	assign line_rdy_o = r.line_rdy;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ACK_TRIG: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& !hend_i.rd && errs == 16'h0000 |=> r.sbuf[7:0] == 8'h84 && r.bits == 7'h08)
		else $error("ack trigger byte wrong");
	AST_RD_ZERO: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& hend_i.rd && !hend_i.rd2 && (errs & ~`DAE_ERR_SB) == 16'h0000 |=> r.sbuf[23:16] == 8'h00)
		else $error("one-byte read high byte not zero");
	AST_REP_DT: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& !hend_i.rd && errs != 16'h0000 |=> r.sbuf[5:0] == 6'h02 && r.bits == 7'h20)
		else $error("error report not framed");
	AST_RSVD_LOW: assert property (r.rep[14] == 1'b0 && r.err[14] == 1'b0)
		else $error("reserved error bit set");
	AST_ACCUM: assert property (r.st != dae_pkg::ST_TURN |=>
		(r.err & $past(r.err)) == $past(r.err))
		else $error("stored error lost before report");
	AST_CLEAR: assert property (r.st == dae_pkg::ST_TURN && err_i == 16'h0000 && !proto
		|=> (r.err & $past(r.rep)) == 16'h0000)
		else $error("reported errors not cleared");
	AST_NO_BTA: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && !hend_i.bta
		|=> r.st == dae_pkg::ST_IDLE)
		else $error("answer without turnaround");
	AST_TURN: assert property (r.st == dae_pkg::ST_SHIFT && rise && r.bits == 7'h00
		|=> turn_o && !tx_oe_o ##1 r.st == dae_pkg::ST_IDLE)
		else $error("no turnaround after transmission");
	AST_MB_NOEXEC: assert property (hend_i.valid && err_i[9] |=> !exec_o)
		else $error("multi-bit error command executed");
	AST_VS_PULSE: assert property (vid_i.valid && vid_i.kind == dae_pkg::PK_VSS
		|=> vsync_o ##1 (vsync_o || r.mode != dae_pkg::VM_PULSE || $past(vid_i.valid)))
		else $error("vsync not raised");

	// Response framing and error capture
	AST_RSP_DT: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& hend_i.rd && errs == 16'h0000
		|=> r.sbuf[5:0] == ($past(hend_i.rd2) ? `DAE_DT_RD2 : `DAE_DT_RD1) && r.bits == 7'h20)
		else $error("read response identifier wrong");
	AST_RSP_DATA: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& hend_i.rd && (errs & ~`DAE_ERR_SB) == 16'h0000
		|=> r.sbuf[15:8] == $past(rd_data_i[7:0]))
		else $error("read data byte wrong");
	AST_RD_PAIR: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& hend_i.rd && errs == `DAE_ERR_SB |=> r.bits == 7'h40 && r.sbuf[37:32] == `DAE_DT_ACKERR)
		else $error("corrected read lacks trailing report");
	AST_RD_MB: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& hend_i.rd && errs[9] |=> r.bits == 7'h20 && r.sbuf[5:0] == `DAE_DT_ACKERR)
		else $error("read data sent despite multi-bit error");
	AST_REP_BYTES: assert property (r.st == dae_pkg::ST_IDLE && hend_i.valid && hend_i.bta
		&& !hend_i.rd && errs != 16'h0000 |=> r.sbuf[23:8] == $past(errs))
		else $error("error field bytes misplaced");
	AST_ERR_SET: assert property (
		(r.err & $past(err_i & `DAE_ERR_KEEP)) == $past(err_i & `DAE_ERR_KEEP))
		else $error("detected error not stored");

	// Reverse lane sequencing
	AST_TX_LSB: assert property (r.st == dae_pkg::ST_SHIFT && rise && r.bits != 7'h00
		|=> tx_bit_o == $past(r.sbuf[0]) && r.bits == $past(r.bits) - 7'h01)
		else $error("reverse lane bit order wrong");
	AST_TURN_ONE: assert property (turn_o |=> !turn_o && r.st == dae_pkg::ST_IDLE)
		else $error("turnaround not a single cycle");

	// Video timing rebuild
	AST_HS_EVENT: assert property (r.mode != dae_pkg::VM_PULSE && r.hcnt == 8'h01
		&& !(vid_i.valid && vid_i.kind == dae_pkg::PK_HSS) |=> !hsync_o)
		else $error("event hsync not ended");
	AST_HS_HOLD: assert property (r.mode == dae_pkg::VM_PULSE && hsync_o && !vid_i.valid
		|=> hsync_o)
		else $error("pulse hsync ended without end packet");
	AST_LINE_RDY: assert property (vid_i.valid && vid_i.kind == dae_pkg::PK_PIXEL
		|=> line_rdy_o == $past(r.line_open))
		else $error("line ready wrong");
	AST_PROTO: assert property (vid_i.valid && vid_i.kind == dae_pkg::PK_PIXEL && !r.line_open
		|=> r.err[15])
		else $error("pixel before line start not flagged");

	// Command execution
	AST_EXEC_OK: assert property (hend_i.valid && !hend_i.rd && err_i == 16'h0000 |=> exec_o)
		else $error("clean command not executed");
	AST_NO_EXEC_RD: assert property (hend_i.valid && hend_i.rd |=> !exec_o)
		else $error("read treated as command");
endmodule

// >>> tb/dae_host_model.sv
/*
 Host link controller model: clocks the reverse lane, captures its bits.
 Assumes tx_oe_i is high for the whole of a device transmission.
*/
`timescale 1ns/1ps
module dae_host_model (
	// Reverse lane
	input  wire logic         tx_bit_i,
	input  wire logic         tx_oe_i,
	// Link clock and capture
	output logic              lclk_o,
	output logic [127:0]      cap_o
);
	logic [6:0] n;
	initial begin
		lclk_o = 1'b0;
		cap_o = '0;
		forever begin
			wait (tx_oe_i);
			cap_o = '0;
			n = '0;
			#13;
			// Clock idles low outside frames
			while (tx_oe_i) begin
				#200 lclk_o = 1'b1;
				// Bit k leaves after rise k, so it is taken at rise k+1
				if (n != 7'h00)
					cap_o[n - 7'h01] = tx_bit_i;
				n = n + 7'h01;
				#200 lclk_o = 1'b0;
			end
		end
	end
endmodule

// >>> tb/dae_top_test.sv
/*
 Self-checking bench: register access, reverse lane answers, execute strobe.
 Assumes dae_regs.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ps
`include "dae_regs.svh"
module dae_top_test;
	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               lclk;
	dae_pkg::dae_wbreq_t wb_i = '0;
	dae_pkg::dae_vid_t  vid_i = '0;
	dae_pkg::dae_hend_t hend_i = '0;
	logic [15:0]        err_i = '0;
	logic [15:0]        rd_data_i = 16'h55A7;
	logic [31:0]        wb_dat_o;
	logic [31:0]        rd;
	logic               wb_ack_o, tx_bit_o, tx_oe_o, turn_o, exec_o, vsync_o, hsync_o, line_rdy_o;
	logic [127:0]       cap;
	logic [15:0]        e;
	int                 err_count = 0;
	int                 n_checks = 0;

	dae_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .vid_i(vid_i), .hend_i(hend_i), .err_i(err_i),
		.rd_data_i(rd_data_i), .lclk_i(lclk), .tx_bit_o(tx_bit_o), .tx_oe_o(tx_oe_o),
		.turn_o(turn_o), .exec_o(exec_o), .vsync_o(vsync_o), .hsync_o(hsync_o),
		.line_rdy_o(line_rdy_o));
	dae_host_model HOST (.tx_bit_i(tx_bit_o), .tx_oe_i(tx_oe_o), .lclk_o(lclk), .cap_o(cap));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		rd = wb_dat_o;
		wb_i <= '0;
		if (i >= 20) begin
			chk(1, 0);
			end_sim();
		end
	endtask

	// Pulse one host transmission end with its error flags
	task automatic host(input logic [3:0] h, input logic [15:0] f);
		@(posedge clk_i);
		hend_i <= h;
		err_i <= f;
		@(posedge clk_i);
		hend_i <= '0;
		err_i <= '0;
		#1;
	endtask

	task automatic vid(input dae_pkg::dae_pkt_t k);
		@(posedge clk_i);
		vid_i <= '{1'b1, k};
		@(posedge clk_i);
		vid_i <= '0;
		#1;
	endtask

	// Short packet on channel 2, byte 0 in the low bits
	function automatic logic [31:0] pkt(input logic [5:0] dt, input logic [7:0] b1, input logic [7:0] b2);
		logic [23:0] d;
		d = {b2, b1, 2'h2, dt};
		return {2'b00, ^(d & `DAE_ECC_P5), ^(d & `DAE_ECC_P4), ^(d & `DAE_ECC_P3),
			^(d & `DAE_ECC_P2), ^(d & `DAE_ECC_P1), ^(d & `DAE_ECC_P0), d};
	endfunction

	task automatic resp(input logic [3:0] h, input logic [15:0] f, input logic [63:0] exp, input int nb);
		int i;
		host(h, f);
		for (i = 0; i < 4000 && turn_o !== 1'b1; i++)
			@(posedge clk_i);
		if (i >= 4000) begin
			chk(1, 0);
			end_sim();
		end
		chk(cap[63:0] & ~({64{1'b1}} << nb), exp);
		repeat (12) @(posedge clk_i);
	endtask

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `DAE_CTRL_ADR, 32'h0);
		chk(rd, 32'h0000_1000);
		wb(1'b1, `DAE_CTRL_ADR, 32'h0000_1008);
		wb(1'b0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
		host(4'b1000, 16'h0000);
		chk(exec_o, 1);
		repeat (20) @(posedge clk_i);
		chk(tx_oe_o, 0);
		resp(4'b1100, 16'h0, 64'h84, 8);
		resp(4'b1110, 16'h0, pkt(`DAE_DT_RD1, 8'hA7, 8'h00), 32);
		resp(4'b1111, 16'h0, pkt(`DAE_DT_RD2, 8'hA7, 8'h55), 32);
		for (int b = 0; b < 16; b++) begin
			e = 16'h0001 << b;
			if (b == 14)
				resp(4'b1100, e, 64'h84, 8);
			else
				resp(4'b1100, e, pkt(`DAE_DT_ACKERR, e[7:0], e[15:8]), 32);
		end
		host(4'b1000, 16'h0200);
		chk(exec_o, 0);
		resp(4'b1100, 16'h0004, pkt(`DAE_DT_ACKERR, 8'h04, 8'h02), 32);
		wb(1'b0, `DAE_ERR_ADR, 32'h0);
		chk(rd, 32'h0);
		resp(4'b1110, 16'h0100, {pkt(`DAE_DT_ACKERR, 8'h00, 8'h01), pkt(`DAE_DT_RD1, 8'hA7, 8'h00)}, 64);
		vid(dae_pkg::PK_PIXEL);
		chk(line_rdy_o, 0);
		wb(1'b0, `DAE_ERR_ADR, 32'h0);
		chk(rd, 32'h8000);
		resp(4'b1100, 16'h0, pkt(`DAE_DT_ACKERR, 8'h00, 8'h80), 32);
		vid(dae_pkg::PK_VSS);
		chk(vsync_o, 1);
		vid(dae_pkg::PK_VSE);
		chk(vsync_o, 0);
		wb(1'b0, `DAE_SYNC_ADR, 32'h0);
		chk(rd, 32'h0000_0004);
		wb(1'b1, `DAE_CTRL_ADR, 32'h0000_0409);
		vid(dae_pkg::PK_HSS);
		chk(hsync_o, 1);
		repeat (3) @(posedge clk_i);
		#1;
		chk(hsync_o, 1);
		@(posedge clk_i);
		#1;
		chk(hsync_o, 0);
		// Porch packets dropped, one blanking packet, then the whole line
		vid(dae_pkg::PK_BLANK);
		vid(dae_pkg::PK_PIXEL);
		chk(line_rdy_o, 1);
		wb(1'b0, `DAE_CNT_ADR, 32'h0);
		chk(rd, 32'h0001_0002);
		wb(1'b0, `DAE_ERR_ADR, 32'h0);
		chk(rd, 32'h0);
		end_sim();
	end
endmodule
